// *** flash_array_model.sv ***
// Purpose: behavioural flash array behind the read controller
// Assumes: word at line l, index i holds {l[12:0], i}
// Notes: flip_i injects one or two bit errors into the low word

`timescale 1ns/100ps

module flash_array_model
  import flash_rd_pkg::*;
(
  input wire logic rd_i, // access in progress
  input wire logic [LINE_W-1:0] line_i, // line address
  input wire logic [1:0] flip_i, // 1: one bad bit, 2: two bad bits
  output flash_line_t data_o // encoded line
);
  // ----------------------------------------------------------------
  // secded encoder
  // ----------------------------------------------------------------
  function automatic ecc_word_t enc(input logic [63:0] d);
    ecc_word_t w;
    int pos;
    w.data = d;
    w.chk = 8'h00;
    pos = 3;
    for (int k = 0; k < 64; k++) begin
      while ((pos & (pos - 1)) == 0) pos++;
      for (int p = 0; p < 7; p++) w.chk[p] ^= d[k] & pos[p];
      pos++;
    end
    w.chk[7] = ^d ^ ^w.chk[6:0];
    return w;
  endfunction

  function automatic logic [63:0] words(input logic [LINE_W-1:0] l,
                                        input logic h);
    logic [63:0] r;
    for (int i = 0; i < 4; i++) r[16*i +: 16] = {l[12:0], h, i[1:0]};
    return r;
  endfunction

  always_comb begin
    data_o.lo = enc(words(line_i, 1'b0));
    data_o.hi = enc(words(line_i, 1'b1));
    if (flip_i != 2'h0) data_o.lo.data[5] = ~data_o.lo.data[5];
    if (flip_i == 2'h2) data_o.lo.data[9] = ~data_o.lo.data[9];
    // no stable value outside an access, so stale reads show up
    if (!rd_i) data_o = ~data_o;
  end
endmodule

// *** flash_rd_pkg.sv ***
// Purpose: shared constants and types of the flash read controller
// Assumes: 16-bit word addressing on the processor side
// Notes: flash lines are 128 bits, two 64-bit ecc-protected words

package flash_rd_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int IDX_W = 3;
  localparam int LINE_W = ADDR_W - IDX_W;
  localparam int PF_DEPTH = 2;
  localparam int DATA_W = 64;
  localparam int SYN_W = 7;
  localparam int CW_BITS = 72;
  localparam int CNT_W = 16;
  localparam int WS_W = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] REG_MASK = 8'h08;
  localparam logic [REG_AW-1:0] REG_THRESH = 8'h0c;
  localparam logic [REG_AW-1:0] REG_ERRCNT = 8'h10;
  localparam int CTRL_PF_POS = 0;
  localparam int CTRL_DC_POS = 1;
  localparam int CTRL_WS_POS = 4;
  localparam int EVT_UNCORR_POS = 0;
  localparam int EVT_THR_POS = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [WS_W-1:0] WS_RST = 4'h3;
  localparam logic PF_EN_RST = 1'b0;
  localparam logic DC_EN_RST = 1'b0;
  localparam logic [CNT_W-1:0] THRESH_RST = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WS_W-1:0] ws;
    logic dc_en;
    logic pf_en;
  } ctrl_t;
  typedef struct packed {
    logic thr;
    logic uncorr;
  } evt_t;
  typedef struct packed {
    logic [CW_BITS-DATA_W-1:0] chk;
    logic [DATA_W-1:0] data;
  } ecc_word_t;
  typedef struct packed {
    ecc_word_t hi;
    ecc_word_t lo;
  } flash_line_t;
  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
  } cpu_req_t;
  typedef struct packed {
    logic ack;
    logic [15:0] data;
  } cpu_rsp_t;
  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_PREF} src_t;
  typedef enum logic {S_IDLE, S_ACCESS} state_t;

  function automatic logic [LINE_W-1:0] line_of(
    input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_W];
  endfunction

  function automatic logic [15:0] pick(input logic [127:0] l,
                                       input logic [IDX_W-1:0] i);
    return l[{i, 4'h0} +: 16];
  endfunction

  // byte-lane merge of a bus write over an old value
  function automatic logic [31:0] wmask(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** flash_read_controller.sv ***
// Purpose: read side of the flash: prefetch, data cache, ecc, wait states
// Assumes: flash array data valid ws+1 cycles after flash_line_o changes
// Notes: one flash access at a time; buffer and cache hits run alongside
//
// Notes on behaviour
// - prefetch next aligned line after last fetch
// - two prefetch entries of 128 bits
// - holds sixteen words, refills while cpu consumes
// - sequential fetch hits answer without wait
// - wait states only after fetch discontinuity
// - prefetch mode enabled by control bit
// - data cache optional, bypassed when disabled
// - data miss captures whole aligned line
// - data hits in cached line answer without wait
// - data miss discards cache and refills
// - each 64-bit word carries secded code
// - correct before buffering, no extra cycle
// - uncorrectable error raises non-maskable request
// - correctable count reaching threshold raises interrupt

`timescale 1ns/100ps

module flash_read_controller
  import flash_rd_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [REG_AW-1:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte enables
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire cpu_req_t if_req_i, // instruction fetch request
  output cpu_rsp_t if_rsp_o, // instruction fetch answer
  input wire cpu_req_t dr_req_i, // data read request
  output cpu_rsp_t dr_rsp_o, // data read answer
  output logic flash_rd_o, // flash access in progress
  output logic [LINE_W-1:0] flash_line_o, // flash line address
  input wire flash_line_t flash_data_i, // raw flash line
  output logic irq_o, // masked event interrupt
  output logic nmi_o // non-maskable uncorrectable error
);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctrl_t ctrl_reg, ctrl_next;
  evt_t status_reg, status_next, mask_reg, mask_next;
  logic [CNT_W-1:0] thresh_reg, thresh_next, cnt_reg, cnt_next;
  logic wb_ack_reg, wb_ack_next, irq_reg, irq_next, nmi_reg, nmi_next;
  logic [31:0] wb_dat_reg, wb_dat_next;
  logic thr_evt;
  state_t st_reg, st_next;
  src_t src_reg, src_next;
  logic [LINE_W-1:0] line_reg, line_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic [WS_W-1:0] wait_reg, wait_next;
  logic rd_reg, rd_next;
  logic [127:0] pf_data_reg [PF_DEPTH];
  logic [127:0] pf_data_next [PF_DEPTH];
  logic [LINE_W-1:0] pf_tag_reg [PF_DEPTH];
  logic [LINE_W-1:0] pf_tag_next [PF_DEPTH];
  logic [PF_DEPTH-1:0] pf_val_reg, pf_val_next;
  logic [LINE_W-1:0] cur_reg, cur_next;
  logic cur_val_reg, cur_val_next;
  logic [127:0] dc_data_reg, dc_data_next;
  logic [LINE_W-1:0] dc_tag_reg, dc_tag_next;
  logic dc_val_reg, dc_val_next;
  cpu_rsp_t if_rsp_reg, if_rsp_next, dr_rsp_reg, dr_rsp_next;

  // ----------------------------------------------------------------
  // ecc check of both halves of the returning line
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] fix_lo, fix_hi;
  logic corr_lo, corr_hi, unc_lo, unc_hi;
  logic [127:0] fix_line;

  secded_word u_ecc_lo (
    .word_i(flash_data_i.lo),
    .data_o(fix_lo),
    .corr_o(corr_lo),
    .uncorr_o(unc_lo)
  );

  secded_word u_ecc_hi (
    .word_i(flash_data_i.hi),
    .data_o(fix_hi),
    .corr_o(corr_hi),
    .uncorr_o(unc_hi)
  );

  assign fix_line = {fix_hi, fix_lo};

  // ----------------------------------------------------------------
  // lookups
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] if_line, dr_line, pf_tgt;
  logic if_go, dr_go, hit0, hit1, if_hit, dc_hit, tgt_held, victim;
  logic capture, any_unc;
  logic [1:0] n_corr;

  assign if_line = line_of(if_req_i.addr);
  assign dr_line = line_of(dr_req_i.addr);
  // a held request is not served twice while its ack is showing
  assign if_go = if_req_i.req && !if_rsp_reg.ack;
  assign dr_go = dr_req_i.req && !dr_rsp_reg.ack;
  assign hit0 = ctrl_reg.pf_en && pf_val_reg[0] && pf_tag_reg[0] == if_line;
  assign hit1 = ctrl_reg.pf_en && pf_val_reg[1] && pf_tag_reg[1] == if_line;
  assign if_hit = hit0 || hit1;
  assign dc_hit = ctrl_reg.dc_en && dc_val_reg && dc_tag_reg == dr_line;
  assign pf_tgt = cur_reg + LINE_W'(1);
  assign tgt_held = (pf_val_reg[0] && pf_tag_reg[0] == pf_tgt) ||
                    (pf_val_reg[1] && pf_tag_reg[1] == pf_tgt);
  // the entry holding the current line is kept, the other refilled
  assign victim = pf_val_reg[0] && pf_tag_reg[0] == cur_reg;
  assign capture = st_reg == S_ACCESS && wait_reg == '0;
  assign any_unc = capture && (unc_lo || unc_hi);
  assign n_corr = capture ? {1'b0, corr_lo} + {1'b0, corr_hi} : 2'h0;

  // ----------------------------------------------------------------
  // read engine
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    src_next = src_reg;
    line_next = line_reg;
    idx_next = idx_reg;
    wait_next = wait_reg;
    rd_next = rd_reg;
    pf_data_next = pf_data_reg;
    pf_tag_next = pf_tag_reg;
    pf_val_next = pf_val_reg;
    cur_next = cur_reg;
    cur_val_next = cur_val_reg;
    dc_data_next = dc_data_reg;
    dc_tag_next = dc_tag_reg;
    dc_val_next = dc_val_reg;
    if_rsp_next = '0;
    dr_rsp_next = '0;
    // hits are answered from storage even while flash is busy
    if (if_go && if_hit) begin
      if_rsp_next.ack = 1'b1;
      if_rsp_next.data = pick(hit1 ? pf_data_reg[1] : pf_data_reg[0],
                              if_req_i.addr[IDX_W-1:0]);
      cur_next = if_line;
    end
    if (dr_go && dc_hit) begin
      dr_rsp_next.ack = 1'b1;
      dr_rsp_next.data = pick(dc_data_reg, dr_req_i.addr[IDX_W-1:0]);
    end
    if (capture) begin
      st_next = S_IDLE;
      rd_next = 1'b0;
      unique case (src_reg)
        SRC_FETCH: begin
          if_rsp_next.ack = 1'b1;
          if_rsp_next.data = pick(fix_line, idx_reg);
          if (ctrl_reg.pf_en) begin
            pf_data_next[0] = fix_line;
            pf_tag_next[0] = line_reg;
            pf_val_next[0] = 1'b1;
          end
        end
        SRC_DATA: begin
          dr_rsp_next.ack = 1'b1;
          dr_rsp_next.data = pick(fix_line, idx_reg);
          if (ctrl_reg.dc_en) begin
            dc_data_next = fix_line;
            dc_tag_next = line_reg;
            dc_val_next = 1'b1;
          end
        end
        SRC_PREF: begin
          // a line overtaken by a jump is dropped, not stored
          if (line_reg == pf_tgt) begin
            pf_data_next[victim] = fix_line;
            pf_tag_next[victim] = line_reg;
            pf_val_next[victim] = 1'b1;
          end
        end
      endcase
    end else if (st_reg == S_IDLE) begin
      // demand fetch first, then data, then background prefetch
      if (if_go && !if_hit) begin
        st_next = S_ACCESS;
        src_next = SRC_FETCH;
        line_next = if_line;
        idx_next = if_req_i.addr[IDX_W-1:0];
        wait_next = ctrl_reg.ws;
        rd_next = 1'b1;
        if (ctrl_reg.pf_en) begin
          pf_val_next = '0;
          cur_next = if_line;
          cur_val_next = 1'b1;
        end
      end else if (dr_go && !dc_hit) begin
        st_next = S_ACCESS;
        src_next = SRC_DATA;
        line_next = dr_line;
        idx_next = dr_req_i.addr[IDX_W-1:0];
        wait_next = ctrl_reg.ws;
        rd_next = 1'b1;
        dc_val_next = 1'b0;
      end else if (ctrl_reg.pf_en && cur_val_reg && !tgt_held) begin
        st_next = S_ACCESS;
        src_next = SRC_PREF;
        line_next = pf_tgt;
        wait_next = ctrl_reg.ws;
        rd_next = 1'b1;
      end
    end else begin
      wait_next = wait_reg - WS_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= S_IDLE;
      src_reg <= SRC_FETCH;
      line_reg <= '0;
      idx_reg <= '0;
      wait_reg <= '0;
      rd_reg <= 1'b0;
      pf_data_reg <= '{default: '0};
      pf_tag_reg <= '{default: '0};
      pf_val_reg <= '0;
      cur_reg <= '0;
      cur_val_reg <= 1'b0;
      dc_data_reg <= '0;
      dc_tag_reg <= '0;
      dc_val_reg <= 1'b0;
      if_rsp_reg <= '0;
      dr_rsp_reg <= '0;
    end else begin
      st_reg <= st_next;
      src_reg <= src_next;
      line_reg <= line_next;
      idx_reg <= idx_next;
      wait_reg <= wait_next;
      rd_reg <= rd_next;
      pf_data_reg <= pf_data_next;
      pf_tag_reg <= pf_tag_next;
      pf_val_reg <= pf_val_next;
      cur_reg <= cur_next;
      cur_val_reg <= cur_val_next;
      dc_data_reg <= dc_data_next;
      dc_tag_reg <= dc_tag_next;
      dc_val_reg <= dc_val_next;
      if_rsp_reg <= if_rsp_next;
      dr_rsp_reg <= dr_rsp_next;
    end
  end

  property p_fetch_hit;
    if_go && if_hit |=> if_rsp_o.ack;
  endproperty
  a_fetch_hit: assert property (p_fetch_hit)
    else $error("buffer hit not answered next cycle");

  property p_dc_hit;
    dr_go && dc_hit |=> dr_rsp_o.ack ##1 !dr_rsp_o.ack;
  endproperty
  a_dc_hit: assert property (p_dc_hit)
    else $error("cache hit not answered once next cycle");

  property p_no_pf;
    st_reg == S_IDLE && if_go && !ctrl_reg.pf_en
      |=> st_reg == S_ACCESS && src_reg == SRC_FETCH;
  endproperty
  a_no_pf: assert property (p_no_pf)
    else $error("fetch with prefetch off skipped flash");

  property p_ws;
    st_reg == S_IDLE && st_next == S_ACCESS
      |=> wait_reg == $past(ctrl_reg.ws) && flash_rd_o;
  endproperty
  a_ws: assert property (p_ws)
    else $error("access did not load wait count");

  property p_flush;
    st_reg == S_IDLE && if_go && !if_hit && ctrl_reg.pf_en
      |=> pf_val_reg == '0 && cur_reg == $past(if_line);
  endproperty
  a_flush: assert property (p_flush)
    else $error("discontinuity kept stale entries");

  property p_pref_seq;
    st_reg == S_IDLE && st_next == S_ACCESS && src_next == SRC_PREF
      |=> flash_line_o == $past(cur_reg) + LINE_W'(1);
  endproperty
  a_pref_seq: assert property (p_pref_seq)
    else $error("prefetch line not the next one");

  property p_dc_fill;
    capture && src_reg == SRC_DATA && ctrl_reg.dc_en
      |=> dc_val_reg && dc_tag_reg == $past(line_reg) && dr_rsp_o.ack;
  endproperty
  a_dc_fill: assert property (p_dc_fill)
    else $error("data miss did not fill cache");

  // ----------------------------------------------------------------
  // register file and events
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd, wm, wz;
    logic acc, wr;
    logic [CNT_W-1:0] base;
    logic [CNT_W:0] sum;
    evt_t set;
    rd = 32'h0;
    wm = 32'h0;
    wz = 32'h0;
    sum = '0;
    set = '0;
    acc = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    wr = acc && wb_we_i;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    thresh_next = thresh_reg;
    base = cnt_reg;
    unique case (wb_adr_i)
      REG_CTRL: begin
        rd[CTRL_PF_POS] = ctrl_reg.pf_en;
        rd[CTRL_DC_POS] = ctrl_reg.dc_en;
        rd[CTRL_WS_POS +: WS_W] = ctrl_reg.ws;
      end
      REG_STATUS: rd[1:0] = status_reg;
      REG_MASK: rd[1:0] = mask_reg;
      REG_THRESH: rd[CNT_W-1:0] = thresh_reg;
      REG_ERRCNT: rd[CNT_W-1:0] = cnt_reg;
      default: rd = 32'h0;
    endcase
    wm = wmask(rd, wb_dat_i, wb_sel_i);
    wz = wmask(32'h0, wb_dat_i, wb_sel_i);
    if (wr) begin
      unique case (wb_adr_i)
        REG_CTRL: begin
          ctrl_next.pf_en = wm[CTRL_PF_POS];
          ctrl_next.dc_en = wm[CTRL_DC_POS];
          ctrl_next.ws = wm[CTRL_WS_POS +: WS_W];
        end
        REG_MASK: mask_next = wm[1:0];
        REG_THRESH: thresh_next = wm[CNT_W-1:0];
        REG_ERRCNT: base = '0;
        default: ;
      endcase
    end
    // counter saturates; a clear in the same cycle keeps new counts
    sum = {1'b0, base} + {{(CNT_W - 1){1'b0}}, n_corr};
    cnt_next = sum[CNT_W] ? '1 : sum[CNT_W-1:0];
    thr_evt = thresh_reg != '0 && base < thresh_reg &&
              cnt_next >= thresh_reg;
    set.uncorr = any_unc;
    set.thr = thr_evt;
    // write-one-to-clear, but a new event wins over the clear
    status_next = (status_reg & ~((wr && wb_adr_i == REG_STATUS) ?
                   evt_t'(wz[1:0]) : evt_t'(2'b00))) | set;
    irq_next = |(status_next & mask_next);
    nmi_next = status_next.uncorr;
    wb_ack_next = acc;
    wb_dat_next = acc ? rd : 32'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '{ws: WS_RST, dc_en: DC_EN_RST, pf_en: PF_EN_RST};
      status_reg <= '0;
      mask_reg <= '0;
      thresh_reg <= THRESH_RST;
      cnt_reg <= '0;
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
      irq_reg <= 1'b0;
      nmi_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      thresh_reg <= thresh_next;
      cnt_reg <= cnt_next;
      wb_ack_reg <= wb_ack_next;
      wb_dat_reg <= wb_dat_next;
      irq_reg <= irq_next;
      nmi_reg <= nmi_next;
    end
  end

  property p_nmi;
    any_unc |=> nmi_o && status_reg.uncorr;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("uncorrectable error did not raise nmi");

  property p_thr;
    thr_evt |=> status_reg.thr ##1
      (irq_o == mask_reg.thr || status_reg.uncorr);
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold did not set status");

  property p_cnt;
    capture && corr_lo && !wb_cyc_i && cnt_reg != '1
      |=> cnt_reg > $past(cnt_reg);
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("corrected error not counted");

  property p_wb;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb: assert property (p_wb)
    else $error("wishbone ack not a single cycle");

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign if_rsp_o = if_rsp_reg;
  assign dr_rsp_o = dr_rsp_reg;
  assign flash_rd_o = rd_reg;
  assign flash_line_o = line_reg;
  assign irq_o = irq_reg;
  assign nmi_o = nmi_reg;

endmodule

// *** secded_word.sv ***
// Purpose: single-error-correct, double-error-detect check of one word
// Assumes: hamming positions 1..71, check bit 7 is even overall parity
// Notes: purely combinational so correction costs no cycle

`timescale 1ns/100ps

module secded_word
  import flash_rd_pkg::*;
(
  input wire ecc_word_t word_i, // stored data with check bits
  output logic [DATA_W-1:0] data_o, // corrected data
  output logic corr_o, // single error seen and fixed
  output logic uncorr_o // double error seen
);

  always_comb begin
    logic [SYN_W-1:0] syn;
    logic par;
    int k;
    syn = '0;
    par = ^word_i;
    k = 0;
    // data bits sit at the non power-of-two positions
    for (int j = 3; j < CW_BITS; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (word_i.data[k]) begin
          syn = syn ^ SYN_W'(j);
        end
        k = k + 1;
      end
    end
    syn = syn ^ word_i.chk[SYN_W-1:0];
    data_o = word_i.data;
    k = 0;
    for (int j = 3; j < CW_BITS; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (par && syn == SYN_W'(j)) begin
          data_o[k] = ~word_i.data[k];
        end
        k = k + 1;
      end
    end
    corr_o = par;
    uncorr_o = !par && syn != '0;
  end

endmodule

// *** tb.sv ***
// Purpose: self-checking bench of the flash read controller
// Assumes: flash model answers combinationally from the line address
// Notes: latency n counts edges from request launch to ack sample

`timescale 1ns/100ps

`define CHK(nm, e, a) begin \
  checks++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("Error %s expected %h seen %h", nm, e, a); \
  end \
end

module tb
  import flash_rd_pkg::*;
;
  logic clk, rst, cyc, stb, we, ack, frd, irq, nmi;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [1:0] flip;
  logic [LINE_W-1:0] fline;
  flash_line_t fdata;
  cpu_req_t if_req, dr_req;
  cpu_rsp_t if_rsp, dr_rsp;
  int fails = 0;
  int checks = 0;
  int cyc_cnt = 0;

  flash_read_controller u_flash_read_controller (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .if_req_i(if_req), .if_rsp_o(if_rsp), .dr_req_i(dr_req),
    .dr_rsp_o(dr_rsp), .flash_rd_o(frd), .flash_line_o(fline),
    .flash_data_i(fdata), .irq_o(irq), .nmi_o(nmi));
  flash_array_model u_flash_array_model (.rd_i(frd), .line_i(fline),
    .flip_i(flip), .data_o(fdata));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk); while (ack !== 1'b1);
    if (!w) `CHK("wb read", e, rdat)
    {cyc, stb} <= 2'b00;
  endtask

  // dp selects the data port; lat is the expected edge count
  task automatic acc(input logic dp, input logic [ADDR_W-1:0] a,
                     input int lat, input logic ck);
    cpu_rsp_t r;
    int n;
    n = 0;
    @(posedge clk);
    if (dp) dr_req <= '{1'b1, a};
    else if_req <= '{1'b1, a};
    do begin
      @(posedge clk);
      n++;
      r = dp ? dr_rsp : if_rsp;
    end while (r.ack !== 1'b1 && n < 50);
    if_req.req <= 1'b0;
    dr_req.req <= 1'b0;
    `CHK("latency", lat, n)
    if (ck) `CHK("read data", a[15:0], r.data)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst <= 1'b1;
    {cyc, stb, we, adr, wdat, sel, flip} <= '0;
    if_req <= '0;
    dr_req <= '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0, 32'h30);
    wb(1'b0, 8'h20, 32'h0, 32'h0);
    acc(1'b0, 22'h40, 6, 1'b1);
    // ws 1 suits a flash at half the cpu rate
    wb(1'b1, REG_CTRL, 32'h10, 32'h0);
    acc(1'b0, 22'h41, 4, 1'b1);
    acc(1'b0, 22'h42, 4, 1'b1);
    wb(1'b1, REG_CTRL, 32'h11, 32'h0);
    acc(1'b0, 22'h100, 4, 1'b1);
    for (int i = 1; i < 32; i++) begin
      acc(1'b0, ADDR_W'(22'h100 + i), 2, 1'b1);
    end
    repeat (8) @(posedge clk);
    acc(1'b0, 22'h300, 4, 1'b1);
    repeat (8) @(posedge clk);
    acc(1'b0, 22'h108, 4, 1'b1);
    wb(1'b1, REG_CTRL, 32'h12, 32'h0);
    acc(1'b1, 22'h200, 4, 1'b1);
    acc(1'b1, 22'h207, 2, 1'b1);
    acc(1'b1, 22'h208, 4, 1'b1);
    acc(1'b1, 22'h201, 4, 1'b1);
    wb(1'b1, REG_CTRL, 32'h10, 32'h0);
    acc(1'b1, 22'h202, 4, 1'b1);
    acc(1'b1, 22'h202, 4, 1'b1);
    wb(1'b1, REG_THRESH, 32'h2, 32'h0);
    wb(1'b1, REG_MASK, 32'h3, 32'h0);
    flip <= 2'h1;
    acc(1'b1, 22'h400, 4, 1'b1);
    acc(1'b1, 22'h410, 4, 1'b1);
    flip <= 2'h0;
    wb(1'b0, REG_ERRCNT, 32'h0, 32'h2);
    wb(1'b0, REG_STATUS, 32'h0, 32'h2);
    `CHK("irq", 1'b1, irq)
    `CHK("nmi", 1'b0, nmi)
    wb(1'b1, REG_STATUS, 32'h2, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    wb(1'b1, REG_MASK, 32'h0, 32'h0);
    flip <= 2'h2;
    acc(1'b1, 22'h420, 4, 1'b0);
    flip <= 2'h0;
    repeat (2) @(posedge clk);
    `CHK("nmi", 1'b1, nmi)
    `CHK("irq", 1'b0, irq)
    wb(1'b1, REG_STATUS, 32'h1, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("nmi", 1'b0, nmi)
    // the double error adds no count; a write clears the counter
    wb(1'b0, REG_ERRCNT, 32'h0, 32'h2);
    wb(1'b1, REG_ERRCNT, 32'h0, 32'h0);
    wb(1'b0, REG_ERRCNT, 32'h0, 32'h0);
    tally_and_finish();
  end
endmodule
